/* rtl/prc_pkg.sv */
// Purpose: Shared constants for the power, reset and event-flag register bank
// Assumes: 8-bit register port, registers at the top of the address map
// Notes: Field positions and reset values live here, except the literal resets of the pin and pulse registers
package prc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 2;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_POWER_CTRL = 8'he0;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'he1;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MASK = 8'he2;
  localparam logic [ADDR_W-1:0] OFS_TOP_SPACE = 8'he0;
  // Field positions of the power and core control register
  localparam int BIT_CORE_RESTART = 7;
  localparam int BIT_FW_ALIVE = 6;
  localparam int BIT_OSC_REQ = 0;
  // Field positions of the flag and mask registers
  localparam int BIT_OBJECT = 0;
  localparam int BIT_HISTOGRAM = 1;
  // Reset values
  localparam logic RST_OSC_REQ = 1'h1;
  localparam logic RST_FW_ALIVE = 1'h0;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 2'h0;
  localparam logic [FLAG_W-1:0] RST_MASK = 2'h0;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
endpackage : prc_pkg

/* rtl/prc_evt_if.sv */
// Purpose: Carries flag and mask traffic between the bank and its event unit
// Assumes: Single clock domain
// Notes: Write strobes are one-cycle pulses
`timescale 1ns/1ps
interface prc_evt_if;
  logic wr_flags;
  logic wr_mask;
  logic core_rst;
  logic [prc_pkg::FLAG_W-1:0] wdata;
  logic [prc_pkg::FLAG_W-1:0] flags;
  logic [prc_pkg::FLAG_W-1:0] mask;
  logic int_n;
  modport ctl (output wr_flags, output wr_mask, output core_rst, output wdata,
    input flags, input mask, input int_n);
  modport evt (input wr_flags, input wr_mask, input core_rst, input wdata,
    output flags, output mask, output int_n);
endinterface : prc_evt_if

/* rtl/prc_event_unit.sv */
// Purpose: Sticky event flags, their enables and the active-low interrupt pin
// Assumes: Event pulses come from logic on the same clock
// Notes: A set arriving with a write-one clear wins over the clear
`timescale 1ns/1ps
module prc_event_unit (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic hist_event_i,
  input wire logic obj_event_i,
  prc_evt_if.evt bus
);
  import prc_pkg::*;

  logic [FLAG_W-1:0] flags_reg;
  logic [FLAG_W-1:0] mask_reg;
  logic int_n_reg;
  wire logic [FLAG_W-1:0] set_vec;
  wire logic [FLAG_W-1:0] clr_vec;
  wire logic [FLAG_W-1:0] flags_next;
  wire logic [FLAG_W-1:0] mask_next;

  // Event sources into their flag positions
  assign set_vec = {hist_event_i, obj_event_i};
  assign clr_vec = bus.wr_flags ? bus.wdata : RST_FLAGS;
  assign flags_next = bus.core_rst ? RST_FLAGS : ((flags_reg & ~clr_vec) | set_vec);
  assign mask_next = bus.core_rst ? RST_MASK : (bus.wr_mask ? bus.wdata : mask_reg);

  // Flag, mask and pin registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      flags_reg <= RST_FLAGS;
      mask_reg <= RST_MASK;
      int_n_reg <= 1'b1;
    end
    else
    begin
      flags_reg <= flags_next;
      mask_reg <= mask_next;
      int_n_reg <= ~|(flags_next & mask_next);
    end
  end

  assign bus.flags = flags_reg;
  assign bus.mask = mask_reg;
  assign bus.int_n = int_n_reg;

  a_flag_set_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    (obj_event_i && !bus.core_rst) |=> flags_reg[BIT_OBJECT]) else $error("object flag not set");
  a_hist_set_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    (hist_event_i && !bus.core_rst) |=> flags_reg[BIT_HISTOGRAM]) else $error("histogram flag not set");
  a_w1c_clears_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (bus.wr_flags && bus.wdata[BIT_OBJECT] && !obj_event_i && !bus.core_rst)
    |=> !flags_reg[BIT_OBJECT]) else $error("write one did not clear flag");
  a_w0_keeps_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (flags_reg[BIT_HISTOGRAM] && bus.wr_flags && !bus.wdata[BIT_HISTOGRAM] && !bus.core_rst)
    |=> flags_reg[BIT_HISTOGRAM]) else $error("write zero changed flag");
  a_pin_low_active: assert property (@(posedge clk_i) disable iff (reset_i)
    |(flags_reg & mask_reg) |-> !int_n_reg) else $error("pin not low with enabled flag");
  a_pin_high_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !(|(flags_reg & mask_reg)) |-> int_n_reg) else $error("pin low with no enabled flag");
  a_mask_blocks_pin: assert property (@(posedge clk_i) disable iff (reset_i)
    (mask_reg == RST_MASK) |-> int_n_reg) else $error("disabled flag drove pin");
endmodule : prc_event_unit

/* rtl/prc_bank.sv */
// Purpose: Host-visible power, core reset and event registers of the sensor module
// Assumes: Serial bus engine presents decoded byte accesses on the same clock
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
module prc_bank (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [prc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [prc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic fw_alive_set_i,
  input wire logic app_running_i,
  input wire logic fw_standby_i,
  input wire logic hist_event_i,
  input wire logic obj_event_i,
  output logic [prc_pkg::DATA_W-1:0] reg_rdata_o,
  output logic lower_space_open_o,
  output logic core_reset_o,
  output logic wake_core_irq_o,
  output logic sleep_core_irq_o,
  output logic app_idle_o,
  output logic osc_enable_o,
  output logic int_n_o
);
  import prc_pkg::*;

  prc_evt_if evt_bus ();

  logic core_rst_reg;
  logic fw_alive_reg;
  logic osc_req_reg;
  logic osc_on_reg;
  logic wake_reg;
  logic sleep_reg;
  logic idle_reg;
  logic [DATA_W-1:0] rdata_reg;

  // Address match shared by write decode and read selection
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction : addr_hit

  // Address decode
  wire logic wr_power = reg_wr_i && addr_hit(reg_addr_i, OFS_POWER_CTRL);
  wire logic wr_flags = reg_wr_i && addr_hit(reg_addr_i, OFS_EVENT_FLAGS);
  wire logic wr_mask = reg_wr_i && addr_hit(reg_addr_i, OFS_EVENT_MASK);
  wire logic restart_req = wr_power && reg_wdata_i[BIT_CORE_RESTART];
  wire logic wake_req = wr_power && reg_wdata_i[BIT_OSC_REQ] && !osc_req_reg;
  wire logic sleep_req = wr_power && !reg_wdata_i[BIT_OSC_REQ];
  wire logic boot_reset = wake_req && !app_running_i;
  wire logic global_rst = restart_req || boot_reset;

  // Power register fields placed by their positions; unused bits read zero
  logic [DATA_W-1:0] power_view;
  always_comb
  begin
    power_view = RD_ZERO;
    power_view[BIT_CORE_RESTART] = core_rst_reg;
    power_view[BIT_FW_ALIVE] = fw_alive_reg;
    power_view[BIT_OSC_REQ] = osc_req_reg;
  end

  // Read multiplexer
  wire logic [DATA_W-1:0] flags_view = {6'h00, evt_bus.flags};
  wire logic [DATA_W-1:0] mask_view = {6'h00, evt_bus.mask};
  wire logic [DATA_W-1:0] rd_sel =
    addr_hit(reg_addr_i, OFS_POWER_CTRL) ? power_view :
    addr_hit(reg_addr_i, OFS_EVENT_FLAGS) ? flags_view :
    addr_hit(reg_addr_i, OFS_EVENT_MASK) ? mask_view : RD_ZERO;

  // Event unit connection
  // A core reset clears the flags, the enables and hence the pin as well
  assign evt_bus.wr_flags = wr_flags;
  assign evt_bus.wr_mask = wr_mask;
  assign evt_bus.core_rst = global_rst;
  assign evt_bus.wdata = reg_wdata_i[FLAG_W-1:0];

  prc_event_unit u_events (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .hist_event_i(hist_event_i),
    .obj_event_i(obj_event_i),
    .bus(evt_bus)
  );

  // Core reset pulse and firmware-alive bit
  // Any core reset drops the alive bit; only firmware can raise it again
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      core_rst_reg <= 1'b0;
      fw_alive_reg <= RST_FW_ALIVE;
    end
    else
    begin
      core_rst_reg <= global_rst;
      fw_alive_reg <= global_rst ? RST_FW_ALIVE : (fw_alive_reg | fw_alive_set_i);
    end
  end

  // Oscillator request and core interrupts
  // Start is pure hardware; stop waits for firmware to report standby, so a
  // core that still runs never loses its clock. The request survives a core reset.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      osc_req_reg <= RST_OSC_REQ;
      osc_on_reg <= RST_OSC_REQ;
      wake_reg <= 1'b0;
      sleep_reg <= 1'b0;
      idle_reg <= 1'b0;
    end
    else
    begin
      if (wr_power)
        osc_req_reg <= reg_wdata_i[BIT_OSC_REQ];
      if (wake_req)
        osc_on_reg <= 1'b1;
      else if (fw_standby_i && !osc_req_reg)
        osc_on_reg <= 1'b0;
      wake_reg <= wake_req;
      sleep_reg <= sleep_req;
      idle_reg <= wake_req && app_running_i;
    end
  end

  // Registered read data; lower space and pin follow state
  // Addresses below the top space read zero here; that space is served elsewhere
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_reg <= RD_ZERO;
    else if (reg_rd_i)
      rdata_reg <= rd_sel;
  end

  assign reg_rdata_o = rdata_reg;
  assign lower_space_open_o = fw_alive_reg;
  assign core_reset_o = core_rst_reg;
  assign wake_core_irq_o = wake_reg;
  assign sleep_core_irq_o = sleep_reg;
  assign app_idle_o = idle_reg;
  assign osc_enable_o = osc_on_reg;
  assign int_n_o = evt_bus.int_n;

  // Core reset path
  a_restart_one_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
    restart_req |=> core_rst_reg ##1 (!core_rst_reg || $past(global_rst)))
    else $error("core reset pulse wrong");
  a_core_rst_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    global_rst |=> (evt_bus.flags == RST_FLAGS) && (evt_bus.mask == RST_MASK) && !fw_alive_reg)
    else $error("core reset left state behind");
  a_restart_self_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (restart_req ##1 !global_rst) |=> !power_view[BIT_CORE_RESTART])
    else $error("restart bit stuck");
  a_pin_after_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    global_rst |=> int_n_o) else $error("pin low after core reset");

  // Firmware-alive bit and register space
  a_alive_needs_fw: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(fw_alive_reg) |-> $past(fw_alive_set_i)) else $error("alive set without firmware");
  a_alive_kept: assert property (@(posedge clk_i) disable iff (reset_i)
    (fw_alive_reg && !global_rst) |=> fw_alive_reg) else $error("alive bit dropped");
  a_lower_space_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    (!fw_alive_reg && !fw_alive_set_i) |=> !lower_space_open_o)
    else $error("lower space open without firmware");
  a_unmapped_reads_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (reg_rd_i && (reg_addr_i < OFS_TOP_SPACE)) |=> (reg_rdata_o == RD_ZERO))
    else $error("lower address read not zero");
  a_read_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data changed without read");
  a_mask_written: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_mask |=> (evt_bus.mask == $past(evt_bus.wdata))) else $error("enable bits not written");

  // Oscillator and core interrupts
  a_osc_on_with_req: assert property (@(posedge clk_i) disable iff (reset_i)
    osc_req_reg |-> osc_enable_o) else $error("oscillator off while requested");
  a_wake_on_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_power && reg_wdata_i[BIT_OSC_REQ] && !osc_req_reg) |=> wake_core_irq_o && osc_enable_o)
    else $error("wake not raised");
  a_no_wake_when_on: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_power && osc_req_reg) |=> !wake_core_irq_o) else $error("spurious wake");
  a_no_pulse_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !reg_wr_i |=> !wake_core_irq_o && !sleep_core_irq_o && !core_reset_o)
    else $error("pulse without write");
  a_sleep_on_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_power && !reg_wdata_i[BIT_OSC_REQ]) |=> sleep_core_irq_o && !osc_req_reg)
    else $error("sleep irq missing");
  a_sleep_no_wake: assert property (@(posedge clk_i) disable iff (reset_i)
    sleep_req |=> !wake_core_irq_o) else $error("wake raised by sleep write");
  a_osc_off_standby: assert property (@(posedge clk_i) disable iff (reset_i)
    (fw_standby_i && !osc_req_reg && !wake_req) |=> !osc_enable_o)
    else $error("oscillator kept after standby");
  a_osc_kept_running: assert property (@(posedge clk_i) disable iff (reset_i)
    (osc_enable_o && !(fw_standby_i && !osc_req_reg)) |=> osc_enable_o)
    else $error("oscillator stopped without firmware");
  a_boot_wake_reset: assert property (@(posedge clk_i) disable iff (reset_i)
    (wake_req && !app_running_i) |=> core_reset_o && !app_idle_o) else $error("boot wake no reset");
  a_app_wake_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    (wake_req && app_running_i && !restart_req) |=> app_idle_o && !core_reset_o)
    else $error("app wake not idle");
  a_idle_needs_wake: assert property (@(posedge clk_i) disable iff (reset_i)
    app_idle_o |-> wake_core_irq_o) else $error("idle without wake");
endmodule : prc_bank

/* test/prc_host_model.sv */
// Purpose: Host side of the register port
// Assumes: One-cycle strobes, launched just after a clock edge
// Notes: Released address and data show inverted values
`timescale 1ns/1ps
module prc_host_model (
  input wire logic clk_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial
  begin
    {reg_wr_o, reg_rd_o} = 2'h0;
    {reg_addr_o, reg_wdata_o} = 16'h0;
  end
  // One byte access, held for one taken edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_i);
    reg_addr_o <= addr;
    reg_wdata_o <= data;
    reg_wr_o <= wr;
    reg_rd_o <= !wr;
    @(posedge clk_i);
    {reg_wr_o, reg_rd_o} <= 2'h0;
    reg_addr_o <= ~addr;
    reg_wdata_o <= ~data;
  endtask : access
endmodule : prc_host_model

/* test/test_power_reset_irq_control.sv */
// Purpose: Self-checking bench of the power and event register bank
// Assumes: Host model drives the register port
// Notes: Flag and mask expectations come from a bench model
`timescale 1ns/1ps
module test_power_reset_irq_control;
  import prc_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic fw_alive_set_i, app_running_i, fw_standby_i, hist_event_i, obj_event_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic reg_wr_i, reg_rd_i, lower_space_open_o, core_reset_o, wake_core_irq_o;
  logic sleep_core_irq_o, app_idle_o, osc_enable_o, int_n_o;
  logic [1:0] fl, mk;
  logic [15:0] ev;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h7412fd94;
  always #5 clk_i = ~clk_i;
  prc_host_model prc_host_model_i (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
  prc_bank prc_bank_i (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .fw_alive_set_i(fw_alive_set_i), .app_running_i(app_running_i), .fw_standby_i(fw_standby_i),
    .hist_event_i(hist_event_i), .obj_event_i(obj_event_i), .reg_rdata_o(reg_rdata_o),
    .lower_space_open_o(lower_space_open_o), .core_reset_o(core_reset_o),
    .wake_core_irq_o(wake_core_irq_o), .sleep_core_irq_o(sleep_core_irq_o),
    .app_idle_o(app_idle_o), .osc_enable_o(osc_enable_o), .int_n_o(int_n_o));
  // Expected pin level from flags and enables
  function automatic logic exp_int_n(input logic [1:0] f, input logic [1:0] m);
    return ~|(f & m);
  endfunction : exp_int_n
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    prc_host_model_i.access(1'b1, a, d);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    prc_host_model_i.access(1'b0, a, 8'h00);
    @(posedge clk_i) #1;
    check("rdata", exp, reg_rdata_o);
  endtask : rd
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // Watchdog against a hung run
  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    {fw_alive_set_i, app_running_i, fw_standby_i, hist_event_i, obj_event_i} = 5'h0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(OFS_POWER_CTRL, 8'h01);
    rd(OFS_EVENT_FLAGS, RD_ZERO);
    rd(OFS_EVENT_MASK, RD_ZERO);
    rd(8'h10, RD_ZERO);
    check("lower_space", 8'h0, lower_space_open_o);
    @(posedge clk_i) fw_alive_set_i <= 1'b1;
    @(posedge clk_i) fw_alive_set_i <= 1'b0;
    rd(OFS_POWER_CTRL, 8'h41);
    check("lower_space", 8'h1, lower_space_open_o);
    $display("test reset and alive done");
    fl = 2'h0;
    repeat (24)
    begin
      ev = 16'($random(seed));
      mk = ev[3:2];
      wr(OFS_EVENT_MASK, {ev[7:4], ev[3:2], ev[3:2]});
      {hist_event_i, obj_event_i} <= ev[1:0];
      @(posedge clk_i) {hist_event_i, obj_event_i} <= 2'h0;
      fl = fl | ev[1:0];
      @(posedge clk_i) #1;
      check("int_n", 8'(exp_int_n(fl, mk)), int_n_o);
      rd(OFS_EVENT_FLAGS, {6'h0, fl});
      rd(OFS_EVENT_MASK, {6'h0, mk});
      wr(OFS_EVENT_FLAGS, ev[15:8]);
      fl = fl & ~ev[9:8];
      @(posedge clk_i) #1;
      check("int_n", 8'(exp_int_n(fl, mk)), int_n_o);
    end
    $display("test flags done");
    wr(OFS_EVENT_MASK, 8'h03);
    wr(OFS_POWER_CTRL, 8'h81);
    check("core_reset", 8'h1, core_reset_o);
    rd(OFS_POWER_CTRL, 8'h01);
    rd(OFS_EVENT_MASK, RD_ZERO);
    check("int_n", 8'h1, int_n_o);
    rd(OFS_EVENT_FLAGS, RD_ZERO);
    // Corner: an event meeting a write-one clear leaves the flag set
    fork
      wr(OFS_EVENT_FLAGS, 8'h01);
      begin
        @(posedge clk_i) obj_event_i <= 1'b1;
        @(posedge clk_i) obj_event_i <= 1'b0;
      end
    join
    rd(OFS_EVENT_FLAGS, 8'h01);
    wr(OFS_EVENT_FLAGS, 8'h01);
    rd(OFS_EVENT_FLAGS, RD_ZERO);
    $display("test restart done");
    wr(OFS_POWER_CTRL, 8'h00);
    check("sleep_irq", 8'h1, sleep_core_irq_o);
    check("osc_enable", 8'h1, osc_enable_o);
    @(posedge clk_i) fw_standby_i <= 1'b1;
    @(posedge clk_i) fw_standby_i <= 1'b0;
    @(posedge clk_i) #1;
    check("osc_enable", 8'h0, osc_enable_o);
    rd(OFS_POWER_CTRL, 8'h00);
    wr(OFS_POWER_CTRL, 8'h01);
    check("wake_irq", 8'h1, wake_core_irq_o);
    check("core_reset", 8'h1, core_reset_o);
    @(posedge clk_i) #1;
    check("osc_enable", 8'h1, osc_enable_o);
    app_running_i <= 1'b1;
    wr(OFS_POWER_CTRL, 8'h00);
    wr(OFS_POWER_CTRL, 8'h01);
    check("app_idle", 8'h1, app_idle_o);
    check("wake_irq", 8'h1, wake_core_irq_o);
    check("core_reset", 8'h0, core_reset_o);
    $display("test oscillator done");
    complete_run();
  end
endmodule : test_power_reset_irq_control
